// >>> pin_prio_pkg.sv
// shared-pin function priority: types and constants
package pin_prio_pkg;

    // arbitration states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARE,
        ST_BLANK,
        ST_BLANK_BO,
        ST_BO_HOLD,
        ST_BUF_WAIT,
        ST_BO
    } prio_state_t;

    // record of the function that holds the shared pin
    typedef enum logic [1:0] {
        FN_NONE,
        FN_ARE,
        FN_BLANK,
        FN_BO
    } func_t;

    // detector requests, one bit each
    typedef struct packed {
        logic are;    // auto-restart enable request
        logic blank;  // extended blanking running
        logic bo;     // brownout condition
        logic ovl;    // overload fault present
    } req_t;

    // resolved actions
    typedef struct packed {
        logic are;    // auto-restart enable action
        logic blank;  // extended blanking allowed to run
        logic bo;     // brownout behaviour
    } grant_t;

    localparam int          REQ_W        = 4;
    localparam req_t        REQ_RST      = 4'h0;
    localparam grant_t      GRANT_RST    = 3'h0;
    localparam prio_state_t STATE_RST    = ST_IDLE;
    localparam func_t       FUNC_RST     = FN_NONE;

    // buffer delay before brownout after an early overload clear
    localparam int          CLK_KHZ      = 200000;
    localparam int          BUF_TIME_MS  = 20;
    localparam int          BUF_CYCLES   = BUF_TIME_MS * CLK_KHZ;

endpackage

// >>> buf_timer.sv
// one-shot delay timer, done is a level until restarted or cleared
module buf_timer
    import pin_prio_pkg::*;
#(
    parameter int CYCLES = BUF_CYCLES,
    parameter int W      = $clog2(CYCLES + 1)
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic start,
    input  wire logic clear,
    output logic      done
);

    // refuse counts that the counter width cannot hold
    if (CYCLES < 1 || W < 1 || W > 31 || CYCLES >= (1 << W)) begin
        $error("buf_timer: CYCLES or W out of range");
    end

    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_q;
    logic         run_q;
    logic         done_q;

    wire at_last = run_q && (cnt_q == LAST);

    // count from start, stop at the last cycle
    always_ff @(posedge clk) begin
        if (srst || clear) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else if (start) begin
            cnt_q  <= '0;
            run_q  <= 1'b1;
            done_q <= 1'b0;
        end else if (at_last) begin
            run_q  <= 1'b0;
            done_q <= 1'b1;
        end else if (run_q) begin
            cnt_q  <= cnt_q + W'(1);
        end
    end

    assign done = done_q;

    // done only ever follows a finished count
    timer_done_a: assert property (@(posedge clk) disable iff (srst)
        $rose(done_q) |-> $past(at_last))
        else $error("timer done without full count");

endmodule

// >>> pin_prio.sv
// shared-pin function priority arbiter
module pin_prio
    import pin_prio_pkg::*;
#(
    parameter int BUF_CYC = BUF_CYCLES
) (
    input  wire logic   clk,
    input  wire logic   srst,
    input  wire req_t   req_raw,
    output grant_t     grant,
    output logic       blank_abort,
    output func_t      first_func
);

    // refuse a buffer delay the timer cannot count
    if (BUF_CYC < 1 || BUF_CYC > 32'h3fffffff) begin
        $error("pin_prio: BUF_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    req_t sync1_q;
    req_t req_q;

    // two flops before any logic looks at the detectors
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= REQ_RST;
            req_q   <= REQ_RST;
        end else begin
            sync1_q <= req_raw;
            req_q   <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // function that a state stands for
    function automatic func_t state_func(input prio_state_t s);
        case (s)
            ST_ARE:                     state_func = FN_ARE;
            ST_BLANK, ST_BLANK_BO:      state_func = FN_BLANK;
            ST_BO_HOLD, ST_BUF_WAIT:    state_func = FN_BLANK;
            ST_BO:                      state_func = FN_BO;
            default:                    state_func = FN_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // arbitration state machine

    prio_state_t state_q;
    prio_state_t state_d;
    logic        early_q;      // overload cleared while blanking ran
    logic        early_d;
    logic        buf_done;

    wire r_are   = req_q.are;
    wire r_blank = req_q.blank;
    wire r_bo    = req_q.bo;
    wire r_ovl   = req_q.ovl;

    wire blank_end   = !r_blank;
    wire buf_start   = (state_q == ST_BLANK_BO) && blank_end && early_q && r_bo && !r_are;
    wire abort_d     = (state_q == ST_BLANK || state_q == ST_BLANK_BO) && r_are;
    wire timer_clr   = (state_q != ST_BUF_WAIT) && !buf_start;  // start wins over clear

    // next state from the current holder and the newcomer
    always_comb begin
        state_d = state_q;
        early_d = early_q;
        case (state_q)
            ST_IDLE: begin
                early_d = 1'b0;
                if (r_are)
                    state_d = ST_ARE;
                else if (r_blank)
                    state_d = ST_BLANK;
                else if (r_bo)
                    state_d = ST_BO;
            end
            ST_ARE: begin
                if (!r_are)
                    state_d = ST_IDLE;               // blanking, brownout ignored
            end
            ST_BLANK: begin
                if (r_are)
                    state_d = ST_ARE;
                else if (blank_end)
                    state_d = ST_IDLE;
                else if (r_bo)
                    state_d = ST_BLANK_BO;
            end
            ST_BLANK_BO: begin
                if (!r_ovl && r_blank)
                    early_d = 1'b1;
                if (r_are)
                    state_d = ST_ARE;
                else if (blank_end) begin
                    if (!r_bo)
                        state_d = ST_IDLE;
                    else if (early_q)
                        state_d = ST_BUF_WAIT;
                    else if (r_ovl)
                        state_d = ST_BO_HOLD;
                    else
                        state_d = ST_BO;
                end
            end
            ST_BO_HOLD: begin
                if (r_are)
                    state_d = ST_ARE;
                else if (!r_bo)
                    state_d = ST_IDLE;
                else if (!r_ovl)
                    state_d = ST_BO;
            end
            ST_BUF_WAIT: begin
                if (r_are)
                    state_d = ST_ARE;
                else if (!r_bo)
                    state_d = ST_IDLE;
                else if (buf_done)
                    state_d = ST_BO;
            end
            ST_BO: begin
                if (!r_bo)
                    state_d = ST_IDLE;               // auto-restart, blanking ignored
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= STATE_RST;
            early_q <= 1'b0;
        end else begin
            state_q <= state_d;
            early_q <= early_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer delay timer

    buf_timer #(
        .CYCLES (BUF_CYC)
    ) u_buf_timer (
        .clk    (clk),
        .srst   (srst),
        .start  (buf_start),
        .clear  (timer_clr),
        .done   (buf_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // registered outputs

    grant_t grant_q;
    grant_t grant_d;
    logic   abort_q;
    func_t  first_q;

    assign grant_d = '{are:   (state_d == ST_ARE),
                       blank: (state_d == ST_BLANK) || (state_d == ST_BLANK_BO),
                       bo:    (state_d == ST_BO)};

    // actions, abort pulse and first-function record
    always_ff @(posedge clk) begin
        if (srst) begin
            grant_q <= GRANT_RST;
            abort_q <= 1'b0;
            first_q <= FUNC_RST;
        end else begin
            grant_q <= grant_d;
            abort_q <= abort_d;
            first_q <= state_func(state_d);
        end
    end

    assign grant       = grant_q;
    assign blank_abort = abort_q;
    assign first_func  = first_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    one_action_a: assert property ($onehot0(grant_q))
        else $error("more than one action granted");

    are_keeps_a: assert property (grant_q.are && req_q.are |=> grant_q.are)
        else $error("auto-restart action lost while requested");

    blank_abort_a: assert property (
        (state_q == ST_BLANK || state_q == ST_BLANK_BO) && req_q.are |=> grant_q.are && blank_abort)
        else $error("blanking not aborted by auto-restart");

    bo_waits_blank_a: assert property (grant_q.blank && req_q.blank && !req_q.are |=> !grant_q.bo)
        else $error("brownout acted during blanking");

    bo_ovl_gone_a: assert property (
        $rose(grant_q.bo) && ($past(state_q) == ST_BLANK_BO || $past(state_q) == ST_BO_HOLD)
        |-> !$past(req_q.ovl))
        else $error("brownout entered with overload present");

    bo_keeps_a: assert property (grant_q.bo && req_q.bo |=> grant_q.bo)
        else $error("brownout left while still present");

    are_over_bo_a: assert property (grant_q.are && req_q.are && req_q.bo |=> !grant_q.bo)
        else $error("later brownout displaced auto-restart");

    buf_wait_a: assert property (
        $past(state_q) == ST_BUF_WAIT && state_q == ST_BO |-> $past(buf_done))
        else $error("brownout before buffer delay expired");

    record_clear_a: assert property (state_q == ST_IDLE ##1 state_q == ST_IDLE |-> first_q == FN_NONE)
        else $error("first-function record not cleared");

    cov_abort_c:   cover property (blank_abort);
    cov_buf_c:     cover property (state_q == ST_BUF_WAIT ##1 state_q == ST_BO);
    cov_hold_c:    cover property (state_q == ST_BO_HOLD ##1 state_q == ST_BO);
    cov_bo_are_c:  cover property (grant_q.bo && req_q.are);

endmodule

// >>> det_model.sv
// detector model: internal fault detectors that feed the arbiter
module det_model
    import pin_prio_pkg::*;
(
    input  wire logic srst,
    input  wire req_t lvl,
    output req_t      req_raw
);
    timeunit 1ns;
    timeprecision 1ps;

    // detector levels; detectors sit idle while the controller is held in reset
    assign req_raw = srst ? REQ_RST : lvl;
endmodule

// >>> test_pin_prio.sv
// self-checking bench for the shared-pin priority arbiter
module test_pin_prio
    import pin_prio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed { grant_t g; logic ab; func_t f; } obs_t;
    typedef struct { obs_t o; int due; } note_t;
    localparam int     BUF   = 16;
    localparam grant_t G_NO  = 3'h0;
    localparam grant_t G_ARE = 3'h4;
    localparam grant_t G_BLK = 3'h2;
    localparam grant_t G_BO  = 3'h1;

    logic   clk     = 1'b0;
    logic   srst    = 1'b1;
    req_t   lvl     = REQ_RST;
    req_t   req_raw;
    grant_t grant;
    logic   blank_abort;
    func_t  first_func;
    int     errors  = 0;
    int     n_tests = 0;
    int     cyc     = 0;
    note_t  exp_q[$];
    obs_t   last;

    ////////////////////////////////////////////////////////////////////////
    // clock, cycle count and instances
    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    det_model dm (.srst(srst), .lvl(lvl), .req_raw(req_raw));
    pin_prio #(.BUF_CYC(BUF)) uut (.clk(clk), .srst(srst), .req_raw(req_raw), .grant(grant),
                                   .blank_abort(blank_abort), .first_func(first_func));

    ////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic fail(input string m);
        errors++;
        $display("mismatch at %0t: %s", $time, m);
    endtask

    task automatic close_out;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // note a result; lat < 0 means arrival cycle not checked here
    task automatic expect_obs(input grant_t g, input logic ab, input func_t f, input int lat);
        note_t n;
        n.o = {g, ab, f};
        n.due = (lat < 0) ? -1 : cyc + lat;
        exp_q.push_back(n);
    endtask

    task automatic put(input req_t v);
        @(negedge clk);
        lvl = v;
    endtask

    // wait for all noted results, then a quiet spell with no stray change
    task automatic settle;
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge clk);
        repeat (8) @(negedge clk);
        n_tests++;
        if (exp_q.size() != 0) begin
            fail("expected result never appeared");
            close_out();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // monitor: each output change takes the oldest note
    always @(negedge clk) begin
        obs_t  now;
        note_t n;
        now = {grant, blank_abort, first_func};
        if (!srst && now !== last) begin
            n_tests++;
            if (exp_q.size() == 0) fail("unexpected output change");
            else begin
                n = exp_q.pop_front();
                if (now !== n.o || (n.due >= 0 && n.due != cyc)) fail("output value or timing differs");
            end
        end
        last = now;
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        req_t v;
        int   t0;
        void'($urandom(63));
        repeat (5) @(negedge clk);
        srst = 1'b0;
        // auto-restart first: later blanking and brownout ignored
        put(4'h8); expect_obs(G_ARE, 1'b0, FN_ARE, 3); settle();
        put(4'hc); settle();
        put(4'he); settle();
        put(4'h0); expect_obs(G_NO, 1'b0, FN_NONE, 3); settle();
        // blanking first: auto-restart aborts it at once
        put(4'h4); expect_obs(G_BLK, 1'b0, FN_BLANK, 3); settle();
        put(4'hc); expect_obs(G_ARE, 1'b1, FN_ARE, 3); expect_obs(G_ARE, 1'b0, FN_ARE, 4); settle();
        put(4'h0); expect_obs(G_NO, 1'b0, FN_NONE, 3); settle();
        // blanking then brownout, overload still present at blanking end
        put(4'h5); expect_obs(G_BLK, 1'b0, FN_BLANK, 3); settle();
        put(4'h7); settle();
        put(4'h3); expect_obs(G_NO, 1'b0, FN_BLANK, 3); settle();
        repeat (BUF + 4) @(negedge clk); // brownout must keep waiting on overload
        put(4'h2); expect_obs(G_BO, 1'b0, FN_BO, 3); settle();
        // brownout held: later auto-restart and blanking ignored
        put(4'ha); settle();
        put(4'he); settle();
        put(4'h0); expect_obs(G_NO, 1'b0, FN_NONE, 3); settle();
        // overload clears before blanking ends: buffer delay before brownout
        put(4'h5); expect_obs(G_BLK, 1'b0, FN_BLANK, 3); settle();
        put(4'h7); put(4'h6); settle();
        put(4'h2); t0 = cyc;
        expect_obs(G_NO, 1'b0, FN_BLANK, 3); expect_obs(G_BO, 1'b0, FN_BO, -1);
        for (int i = 0; i < BUF + 20 && grant !== G_BO; i++) @(negedge clk);
        n_tests++;
        if (cyc - t0 < BUF + 3 || cyc - t0 > BUF + 5) fail("buffer delay before brownout wrong");
        settle();
        put(4'h0); expect_obs(G_NO, 1'b0, FN_NONE, 3); settle();
        // random simultaneous first requests from idle
        for (int k = 0; k < 6; k++) begin
            v = req_t'(4'($urandom));
            if (v[3:1] == 3'h0) v.bo = 1'b1;
            if (!v.are && v.blank) v.bo = 1'b0;
            put(v);
            if (v.are) expect_obs(G_ARE, 1'b0, FN_ARE, 3);
            else if (v.blank) expect_obs(G_BLK, 1'b0, FN_BLANK, 3);
            else expect_obs(G_BO, 1'b0, FN_BO, 3);
            settle();
            put(4'h0); expect_obs(G_NO, 1'b0, FN_NONE, 3); settle();
        end
        // mid-run reset while auto-restart held: outputs clear, then re-arbitrate
        put(4'h8); expect_obs(G_ARE, 1'b0, FN_ARE, 3); settle();
        srst = 1'b1;
        repeat (3) @(negedge clk);
        n_tests++;
        if (grant !== G_NO || blank_abort !== 1'b0 || first_func !== FN_NONE) fail("outputs not cleared by reset");
        srst = 1'b0;
        expect_obs(G_ARE, 1'b0, FN_ARE, 3); settle();
        put(4'h0); expect_obs(G_NO, 1'b0, FN_NONE, 3); settle();
        close_out();
    end
endmodule
